// ==== drcr_pkg.sv ====
// constants for the dual receiver control register slice
//
// Operation
// R1 - mode 0: lock only with active video
// R2 - mode 1: lock whenever linked to serializer
// R3 - raw back channel passes remote_io_zero unfiltered
// R4 - lane mode field selects auto/two/one lane
// R5 - second port select: write port1, read port1
// R6 - host clears second select before port0 reads
// R7 - first port select resets to one
// R8 - both selects set: reads return port1
// R9 - second select steers equalizer register to port1
// R10 - restart bit never self clears
// R11 - restart hits both ports always
// R12 - floor start needs floor override set
// R13 - active floor start begins from preset floor
// R14 - video off flag comes from serializer
// R15 - two lane status is read only link status
// R16 - reserved bits read zero, writes ignored
package drcr_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] DRCR_ADDR_RX_CTL = 8'h34;
    localparam logic [7:0] DRCR_ADDR_EQ_TEST = 8'h35;
    // ************************************************************
    // receiver control fields
    // ************************************************************
    localparam int DRCR_BIT_LOCK_MODE = 6;
    localparam int DRCR_BIT_RAW_BC = 5;
    localparam int DRCR_LANE_HI = 4;
    localparam int DRCR_LANE_LO = 3;
    localparam int DRCR_BIT_PORT1 = 1;
    localparam int DRCR_BIT_PORT0 = 0;
    localparam logic [7:0] DRCR_RX_CTL_RESET = 8'h01;
    localparam logic [7:0] DRCR_RX_CTL_MASK = 8'h7B;
    // ************************************************************
    // equalizer test fields
    // ************************************************************
    localparam int DRCR_BIT_EQ_RESTART = 6;
    localparam int DRCR_BIT_FLOOR_OVR = 5;
    localparam int DRCR_BIT_FLOOR_START = 4;
    localparam logic [7:0] DRCR_EQ_RESET = 8'h00;
    localparam logic [7:0] DRCR_EQ_MASK = 8'h70;
    // ************************************************************
    // lane mode encodings
    // ************************************************************
    typedef enum logic [1:0] {
        DRCR_LANE_AUTO = 2'h0,
        DRCR_LANE_TWO = 2'h1,
        DRCR_LANE_ONE_PRI = 2'h2,
        DRCR_LANE_ONE_SEC = 2'h3
    } drcr_lane_t;
endpackage

// ==== drcr_regs.sv ====
// dual receiver control and equalizer test registers with their effects
module drcr_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register access from the i2c slave, primary address
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // receiver core status
    input wire logic link_up,
    input wire logic fwd_video_off,
    input wire logic fwd_two_lane,
    output logic rx_lock,
    output logic two_lane_status,
    // back channel
    input wire logic remote_io_zero,
    input wire logic remote_io_zero_filtered,
    output logic back_channel_bit,
    // receiver mode and port steering
    output logic [1:0] serial_input_lane_mode,
    output logic port0_write_en,
    output logic port1_write_en,
    output logic read_port1,
    // equalizer controls, per port
    output logic eq0_restart,
    output logic eq1_restart,
    output logic eq0_floor_start,
    output logic eq1_floor_start
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] rx_ctl; // receiver control, reserved bits held zero
    logic [7:0] eq_port0; // equalizer test copy for port 0
    logic [7:0] eq_port1; // equalizer test copy for port 1
    logic [7:0] rdata_q; // registered read data

    // ************************************************************
    // helpers
    // ************************************************************
    // floor start counts only while its override is also set
    function automatic logic floor_active(input logic [7:0] eq_reg);
        floor_active = eq_reg[drcr_pkg::DRCR_BIT_FLOOR_OVR] && eq_reg[drcr_pkg::DRCR_BIT_FLOOR_START]; // [R12] [R13]
    endfunction
    // restart bit of one equalizer copy; it holds until the host clears it
    function automatic logic restart_set(input logic [7:0] eq_reg);
        restart_set = eq_reg[drcr_pkg::DRCR_BIT_EQ_RESTART]; // [R10]
    endfunction

    // ************************************************************
    // decode
    // ************************************************************
    wire hit_ctl = (reg_addr == drcr_pkg::DRCR_ADDR_RX_CTL);
    wire hit_eq = (reg_addr == drcr_pkg::DRCR_ADDR_EQ_TEST);
    wire sel0 = rx_ctl[drcr_pkg::DRCR_BIT_PORT0];
    wire sel1 = rx_ctl[drcr_pkg::DRCR_BIT_PORT1];
    // second port select takes the equalizer copy [R9]
    wire wr_eq1 = reg_wr && hit_eq && sel1;
    wire wr_eq0 = reg_wr && hit_eq && sel0 && !sel1;
    // port1 wins on reads when both are selected [R8]
    wire [7:0] eq_view = sel1 ? eq_port1 : eq_port0;
    wire [7:0] next_rdata = hit_ctl ? rx_ctl : (hit_eq ? eq_view : 8'h00);

    // ************************************************************
    // control register; reset leaves port0 selected
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_ctl <= drcr_pkg::DRCR_RX_CTL_RESET; // [R7]
        end else if (reg_wr && hit_ctl) begin
            rx_ctl <= reg_wdata & drcr_pkg::DRCR_RX_CTL_MASK; // [R16]
        end
    end

    // ************************************************************
    // equalizer copies; restart bit is stored, never self cleared
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            eq_port0 <= drcr_pkg::DRCR_EQ_RESET;
            eq_port1 <= drcr_pkg::DRCR_EQ_RESET;
        end else begin
            if (wr_eq0) begin
                eq_port0 <= reg_wdata & drcr_pkg::DRCR_EQ_MASK; // [R10] [R16]
            end
            if (wr_eq1) begin
                eq_port1 <= reg_wdata & drcr_pkg::DRCR_EQ_MASK; // [R10] [R16]
            end
        end
    end

    // ************************************************************
    // read data, held from the read strobe
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= next_rdata; // [R16]
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata = rdata_q;
    assign reg_hit = hit_ctl || hit_eq;
    // mode 1 ignores video off, mode 0 needs active video [R1] [R2] [R14]
    assign rx_lock = link_up && (rx_ctl[drcr_pkg::DRCR_BIT_LOCK_MODE] || !fwd_video_off);
    // link status straight from the forward channel, not writable [R15]
    assign two_lane_status = fwd_two_lane;
    // raw mode bypasses the oversampling filter [R3]
    assign back_channel_bit = rx_ctl[drcr_pkg::DRCR_BIT_RAW_BC] ? remote_io_zero : remote_io_zero_filtered;
    assign serial_input_lane_mode = rx_ctl[drcr_pkg::DRCR_LANE_HI:drcr_pkg::DRCR_LANE_LO]; // [R4]
    // each set select enables its own copies; with both set both are written [R5] [R7]
    assign port0_write_en = reg_wr && sel0; // [R7]
    assign port1_write_en = reg_wr && sel1; // [R5]
    assign read_port1 = sel1; // [R8]
    // either copy's restart bit restarts both ports [R11]
    wire restart_any = restart_set(eq_port0) || restart_set(eq_port1);
    assign eq0_restart = restart_any;
    assign eq1_restart = restart_any;
    // floor start gated by its override [R12] [R13]
    assign eq0_floor_start = floor_active(eq_port0);
    assign eq1_floor_start = floor_active(eq_port1);

    // ************************************************************
    // checks
    // ************************************************************
    property p_lock_mode0;
        @(posedge clk) disable iff (reset)
        (!rx_ctl[drcr_pkg::DRCR_BIT_LOCK_MODE] && fwd_video_off) |-> !rx_lock;
    endproperty
    a_lock_mode0: assert property (p_lock_mode0) else $error("lock with video off in mode 0"); // [R1]

    property p_lock_mode1;
        @(posedge clk) disable iff (reset)
        (rx_ctl[drcr_pkg::DRCR_BIT_LOCK_MODE] && link_up) |-> rx_lock;
    endproperty
    a_lock_mode1: assert property (p_lock_mode1) else $error("no lock while linked in mode 1"); // [R2]

    property p_raw_bc;
        @(posedge clk) disable iff (reset)
        rx_ctl[drcr_pkg::DRCR_BIT_RAW_BC] |-> (back_channel_bit == remote_io_zero);
    endproperty
    a_raw_bc: assert property (p_raw_bc) else $error("raw back channel not passed through"); // [R3]

    property p_lane_write;
        @(posedge clk) disable iff (reset)
        (reg_wr && hit_ctl) |=> (serial_input_lane_mode == $past(reg_wdata[drcr_pkg::DRCR_LANE_HI:drcr_pkg::DRCR_LANE_LO]));
    endproperty
    a_lane_write: assert property (p_lane_write) else $error("lane mode not written"); // [R4]

    property p_read_port1;
        @(posedge clk) disable iff (reset)
        (reg_rd && hit_eq && sel1 && !wr_eq1) |=> (reg_rdata == $past(eq_port1));
    endproperty
    a_read_port1: assert property (p_read_port1) else $error("port1 copy not read"); // [R8]

    property p_restart_hold;
        @(posedge clk) disable iff (reset)
        (eq_port1[drcr_pkg::DRCR_BIT_EQ_RESTART] && !wr_eq1) |=> eq_port1[drcr_pkg::DRCR_BIT_EQ_RESTART];
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart cleared itself"); // [R10]

    property p_restart_both;
        @(posedge clk) disable iff (reset)
        eq0_restart |-> eq1_restart;
    endproperty
    a_restart_both: assert property (p_restart_both) else $error("restart not on both ports"); // [R11]

    property p_floor_gate;
        @(posedge clk) disable iff (reset)
        !eq_port0[drcr_pkg::DRCR_BIT_FLOOR_OVR] |-> !eq0_floor_start;
    endproperty
    a_floor_gate: assert property (p_floor_gate) else $error("floor start without override"); // [R12]

    property p_reserved;
        @(posedge clk) disable iff (reset)
        ((rx_ctl & ~drcr_pkg::DRCR_RX_CTL_MASK) == 8'h00) && ((eq_port0 & ~drcr_pkg::DRCR_EQ_MASK) == 8'h00)
        && ((eq_port1 & ~drcr_pkg::DRCR_EQ_MASK) == 8'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [R16]

    property p_reset_sel0;
        @(posedge clk) $fell(reset) |-> sel0 && !sel1;
    endproperty
    a_reset_sel0: assert property (p_reset_sel0) else $error("port0 select not set at reset"); // [R7]

    property p_lock_mode0_on;
        @(posedge clk) disable iff (reset)
        (!rx_ctl[drcr_pkg::DRCR_BIT_LOCK_MODE] && link_up && !fwd_video_off) |-> rx_lock;
    endproperty
    a_lock_mode0_on: assert property (p_lock_mode0_on) else $error("no lock with active video in mode 0"); // [R1]

    property p_lock_unlinked;
        @(posedge clk) disable iff (reset)
        !link_up |-> !rx_lock;
    endproperty
    a_lock_unlinked: assert property (p_lock_unlinked) else $error("lock without link"); // [R2]

    property p_video_on;
        @(posedge clk) disable iff (reset)
        (link_up && !fwd_video_off) |-> rx_lock;
    endproperty
    a_video_on: assert property (p_video_on) else $error("no lock with link and video"); // [R14]

    property p_filtered_bc;
        @(posedge clk) disable iff (reset)
        !rx_ctl[drcr_pkg::DRCR_BIT_RAW_BC] |-> (back_channel_bit == remote_io_zero_filtered);
    endproperty
    a_filtered_bc: assert property (p_filtered_bc) else $error("filtered back channel not used"); // [R3]

    property p_lane_hold;
        @(posedge clk) disable iff (reset)
        !(reg_wr && hit_ctl) |=> $stable(serial_input_lane_mode);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("lane mode changed without write"); // [R4]

    property p_port1_write;
        @(posedge clk) disable iff (reset)
        (reg_wr && sel1) |-> port1_write_en;
    endproperty
    a_port1_write: assert property (p_port1_write) else $error("port1 copies not written"); // [R5]

    property p_port0_write;
        @(posedge clk) disable iff (reset)
        (reg_wr && sel0) |-> port0_write_en;
    endproperty
    a_port0_write: assert property (p_port0_write) else $error("port0 copies not written"); // [R7]

    property p_no_write_idle;
        @(posedge clk) disable iff (reset)
        !reg_wr |-> (!port0_write_en && !port1_write_en);
    endproperty
    a_no_write_idle: assert property (p_no_write_idle) else $error("write enable without strobe"); // [R5]

    property p_eq1_steer;
        @(posedge clk) disable iff (reset)
        (reg_wr && hit_eq && sel1) |=> $stable(eq_port0);
    endproperty
    a_eq1_steer: assert property (p_eq1_steer) else $error("port0 equalizer touched by port1 write"); // [R9]

    property p_eq1_written;
        @(posedge clk) disable iff (reset)
        (reg_wr && hit_eq && sel1) |=> (eq_port1 == ($past(reg_wdata) & drcr_pkg::DRCR_EQ_MASK));
    endproperty
    a_eq1_written: assert property (p_eq1_written) else $error("port1 equalizer not written"); // [R9]

    property p_eq0_written;
        @(posedge clk) disable iff (reset)
        (reg_wr && hit_eq && sel0 && !sel1) |=> (eq_port0 == ($past(reg_wdata) & drcr_pkg::DRCR_EQ_MASK));
    endproperty
    a_eq0_written: assert property (p_eq0_written) else $error("port0 equalizer not written"); // [R7]

    property p_read_port0;
        @(posedge clk) disable iff (reset)
        (reg_rd && hit_eq && sel0 && !sel1) |=> (reg_rdata == $past(eq_port0));
    endproperty
    a_read_port0: assert property (p_read_port0) else $error("port0 copy not read"); // [R7]

    property p_read_ctl;
        @(posedge clk) disable iff (reset)
        (reg_rd && hit_ctl) |=> (reg_rdata == $past(rx_ctl));
    endproperty
    a_read_ctl: assert property (p_read_ctl) else $error("shared control register not read"); // [R5]

    property p_read_unmapped;
        @(posedge clk) disable iff (reset)
        (reg_rd && !reg_hit) |=> (reg_rdata == 8'h00);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero"); // [R16]

    property p_restart_any;
        @(posedge clk) disable iff (reset)
        (restart_set(eq_port0) || restart_set(eq_port1)) |-> (eq0_restart && eq1_restart);
    endproperty
    a_restart_any: assert property (p_restart_any) else $error("restart missed a port"); // [R11]

    property p_restart_idle;
        @(posedge clk) disable iff (reset)
        !(restart_set(eq_port0) || restart_set(eq_port1)) |-> !(eq0_restart || eq1_restart);
    endproperty
    a_restart_idle: assert property (p_restart_idle) else $error("restart without restart bit"); // [R10]

    property p_restart_hold0;
        @(posedge clk) disable iff (reset)
        (eq_port0[drcr_pkg::DRCR_BIT_EQ_RESTART] && !wr_eq0) |=> eq_port0[drcr_pkg::DRCR_BIT_EQ_RESTART];
    endproperty
    a_restart_hold0: assert property (p_restart_hold0) else $error("port0 restart cleared itself"); // [R10]

    property p_floor_start1;
        @(posedge clk) disable iff (reset)
        (eq_port1[drcr_pkg::DRCR_BIT_FLOOR_OVR] && eq_port1[drcr_pkg::DRCR_BIT_FLOOR_START]) |-> eq1_floor_start;
    endproperty
    a_floor_start1: assert property (p_floor_start1) else $error("port1 floor start missing"); // [R13]

    property p_floor_gate1;
        @(posedge clk) disable iff (reset)
        !eq_port1[drcr_pkg::DRCR_BIT_FLOOR_OVR] |-> !eq1_floor_start;
    endproperty
    a_floor_gate1: assert property (p_floor_gate1) else $error("port1 floor start without override"); // [R12]

    property p_two_lane;
        @(posedge clk) disable iff (reset)
        two_lane_status == fwd_two_lane;
    endproperty
    a_two_lane: assert property (p_two_lane) else $error("two lane status not from link"); // [R15]
endmodule

// ==== drcr_ser_model.sv ====
// remote serializer model driving the forward channel status flags
module drcr_ser_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // scenario commands from the bench
    input wire logic want_link,
    input wire logic want_voff,
    input wire logic want_two,
    // forward channel status toward the receiver
    output logic link_up,
    output logic fwd_video_off,
    output logic fwd_two_lane
);
    // flags arrive over the link, so they lag the command by one cycle
    // with no link the flags fall back to zero, never a stale value
    always_ff @(posedge clk) begin
        if (reset) begin
            link_up <= 1'b0;
            fwd_video_off <= 1'b0;
            fwd_two_lane <= 1'b0;
        end else begin
            link_up <= want_link;
            fwd_video_off <= want_voff & want_link;
            fwd_two_lane <= want_two & want_link;
        end
    end
endmodule

// ==== dual_receiver_control_regs_test.sv ====
// self-checking bench for the dual receiver control registers
module dual_receiver_control_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    // bench-driven inputs, all defined at time zero
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic remote_io_zero = 1'b0, remote_io_zero_filtered = 1'b0;
    logic want_link = 1'b0, want_voff = 1'b0, want_two = 1'b0;
    // design outputs
    logic reg_hit, link_up, fwd_video_off, fwd_two_lane, rx_lock, two_lane_status;
    logic back_channel_bit, port0_write_en, port1_write_en, read_port1;
    logic [1:0] serial_input_lane_mode;
    logic eq0_restart, eq1_restart, eq0_floor_start, eq1_floor_start;
    int n_mismatch = 0, checked = 0;
    drcr_regs drcr_regs_inst (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
        .link_up, .fwd_video_off, .fwd_two_lane, .rx_lock, .two_lane_status, .remote_io_zero,
        .remote_io_zero_filtered, .back_channel_bit, .serial_input_lane_mode, .port0_write_en,
        .port1_write_en, .read_port1, .eq0_restart, .eq1_restart, .eq0_floor_start, .eq1_floor_start);
    drcr_ser_model drcr_ser_model_inst (.clk, .reset, .want_link, .want_voff, .want_two,
        .link_up, .fwd_video_off, .fwd_two_lane);
    // 10 MHz clock
    initial forever #50 clk = ~clk;
    // byte compare; case inequality so unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // single flag compare
    task automatic flag(input logic f, input logic e);
        chk({7'h00, f}, {7'h00, e});
    endtask
    // one-cycle write strobe, result visible after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data registered at the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // command the serializer and let its flags settle
    task automatic ser(input logic l, input logic v, input logic t);
        @(posedge clk);
        want_link <= l;
        want_voff <= v;
        want_two <= t;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rd(8'h34, 8'h01);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h00);
        flag(read_port1, 1'b0);
    endtask
    task automatic t_lock;
        ser(1'b1, 1'b1, 1'b1);
        flag(rx_lock, 1'b0);
        flag(two_lane_status, 1'b1);
        wr(8'h34, 8'h41);
        flag(rx_lock, 1'b1);
        ser(1'b0, 1'b0, 1'b0);
        flag(rx_lock, 1'b0);
        ser(1'b1, 1'b0, 1'b0);
        wr(8'h34, 8'h01);
        flag(rx_lock, 1'b1);
    endtask
    task automatic t_mode;
        for (int i = 0; i < 4; i++) begin
            wr(8'h34, {3'h0, i[1:0], 3'h1});
            chk({6'h00, serial_input_lane_mode}, i[7:0]);
        end
        wr(8'h34, 8'hFF);
        rd(8'h34, 8'h7B);
        @(posedge clk);
        remote_io_zero <= 1'b1;
        #1 flag(back_channel_bit, 1'b1);
        wr(8'h34, 8'h01);
        flag(back_channel_bit, 1'b0);
    endtask
    task automatic t_port;
        wr(8'h35, 8'h30);
        flag(eq0_floor_start, 1'b1);
        flag(eq1_floor_start, 1'b0);
        wr(8'h34, 8'h03);
        flag(read_port1, 1'b1);
        wr(8'h35, 8'h10);
        flag(eq1_floor_start, 1'b0);
        rd(8'h35, 8'h10);
        wr(8'h34, 8'h02);
        rd(8'h35, 8'h10);
        wr(8'h34, 8'h01);
        rd(8'h35, 8'h30);
        wr(8'h35, 8'hFF);
        rd(8'h35, 8'h70);
        flag(eq1_restart, 1'b1);
        repeat (5) @(posedge clk);
        #1 flag(eq0_restart, 1'b1);
        wr(8'h35, 8'h00);
        flag(eq1_restart, 1'b0);
        wr(8'h35, 8'h30);
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h40);
        flag(eq0_restart, 1'b1);
        flag(eq0_floor_start, 1'b1);
        wr(8'h35, 8'h00);
        flag(eq0_restart, 1'b0);
        wr(8'h34, 8'h01);
        rd(8'h35, 8'h30);
    endtask
    // unmapped write strobe; write enables are judged while it stands
    task automatic strobe(input logic e0, input logic e1);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h36;
        reg_wdata <= 8'hFF;
        #1 flag(port0_write_en, e0);
        flag(port1_write_en, e1);
        flag(reg_hit, 1'b0);
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic t_steer;
        wr(8'h34, 8'h03);
        strobe(1'b1, 1'b1);
        wr(8'h34, 8'h02);
        strobe(1'b0, 1'b1);
        wr(8'h34, 8'h01);
        strobe(1'b1, 1'b0);
        flag(port0_write_en, 1'b0);
        rd(8'h34, 8'h01);
        flag(reg_hit, 1'b1);
    endtask
    // reset in mid-run brings both registers back
    task automatic t_rereset;
        wr(8'h34, 8'h5A);
        rd(8'h34, 8'h5A);
        wr(8'h35, 8'h30);
        flag(eq1_floor_start, 1'b1);
        @(posedge clk);
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(8'h34, 8'h01);
        rd(8'h35, 8'h00);
        flag(eq1_floor_start, 1'b0);
    endtask
    // verdict and end of run
    task automatic summarize;
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog: the run needs about 130 cycles, allow ten thousand
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_lock();
        t_mode();
        t_port();
        t_steer();
        t_rereset();
        summarize();
    end
endmodule
